// *** bench/watchdog_and_address_trap_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module watchdog_and_address_trap_tb;
    localparam logic [7:0] C1 = wdat_pkg::CTRL_ONE_ADDR;
    localparam logic [7:0] CM = wdat_pkg::CMD_ADDR;
    localparam logic [7:0] ST = wdat_pkg::STATUS_ADDR;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr, wdata, rdata;
    logic wr_stb, rd_stb, fetch_valid;
    logic [15:0] fetch_addr;
    logic low_speed = 1'b0;
    logic hold = 1'b0;
    logic osc_ready = 1'b1;
    logic fs_tick = 1'b0;
    logic div_sel = 1'b0;
    logic wnmi, tnmi, pin_o, pin_oe, int_rst, osc_restart;
    int fails = 0;
    int checks = 0;
    int oe_cyc = 0;
    int wn = 0;
    int tn = 0;
    int cyc = 0;
    int b0, b1;
    always #2 clock = ~clock;
    // short taps keep overflow at 24 to 32 cycles with detect field 11
    wdat_top #(.FC_TAP_BASE(8), .FS_TAP_BASE(8)) wdat_top_i (
        .clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
        .low_speed_clock_mode(low_speed), .divider_stage_clock_select(div_sel),
        .fs_tick(fs_tick), .clock_hold(hold), .hf_osc_ready(osc_ready),
        .overflow_nmi_request(wnmi), .fetch_trap_nmi_request(tnmi),
        .reset_pin_o(pin_o), .reset_pin_oe(pin_oe), .internal_reset(int_rst),
        .hf_osc_restart(osc_restart)
    );
    wdat_cpu_model wdat_cpu_model_i (
        .clock(clock), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
        .overflow_nmi_request(wnmi), .fetch_trap_nmi_request(tnmi)
    );
    task automatic summarize();
        if (fails == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        fs_tick <= (cyc % 4 == 0);
        if (wnmi === 1'b1) wn <= wn + 1;
        if (tnmi === 1'b1) tn <= tn + 1;
        if (pin_oe === 1'b1) oe_cyc <= oe_cyc + 1;
        if (nrst && (int_rst !== pin_oe || pin_o !== 1'b0)) begin
            fails = fails + 1;
            $display("Error %0t: reset outputs disagree", $time);
        end
        if (cyc == 3000) begin
            fails = fails + 1;
            $display("Error %0t: timeout", $time);
            summarize();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_n(input int got, input int exp);
        checks++;
        if (got != exp) begin
            fails++;
            $display("Error %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
        logic [7:0] d;
        wdat_cpu_model_i.rd(a, d);
        chk(d & m, exp);
    endtask
    function automatic int pick(input int which);
        return which == 0 ? oe_cyc : (which == 1 ? wn : tn);
    endfunction
    task automatic wait_chg(input int which, input int lim);
        int base;
        base = pick(which);
        for (int i = 0; i < lim && pick(which) == base; i++) @(posedge clock);
        repeat (2) @(posedge clock);
    endtask
    task automatic fetch_chk(input logic [15:0] a, input logic [15:0] b, input int n, input int exp);
        int t;
        t = tn;
        wdat_cpu_model_i.fetch(a, b, n);
        repeat (2) @(posedge clock);
        chk_n(tn - t, exp);
    endtask
    initial begin
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        rd_chk(ST, 8'hff, 8'h0f);
        rd_chk(8'h50, 8'hff, 8'h00);
        wdat_cpu_model_i.wr(C1, 8'h3f);
        wdat_cpu_model_i.wr(CM, 8'h4e);
        b0 = oe_cyc;
        repeat (20) @(posedge clock);
        chk_n(oe_cyc - b0, 0);
        wait_chg(0, 40);
        // clearing well inside 3/4 of the period must hold off overflow
        repeat (12) begin
            wdat_cpu_model_i.wr(CM, 8'h4e);
            repeat (10) @(posedge clock);
        end
        chk_n(oe_cyc - b0, 24);
        wdat_cpu_model_i.wr(CM, 8'hb1);
        rd_chk(ST, 8'h0f, 8'h0f);
        wdat_cpu_model_i.master_off();
        wdat_cpu_model_i.wr(CM, 8'h4e);
        wdat_cpu_model_i.wr(C1, 8'h37);
        wdat_cpu_model_i.wr(CM, 8'hb1);
        repeat (100) @(posedge clock);
        rd_chk(ST, 8'hff, 8'h0e);
        chk_n(oe_cyc - b0, 24);
        wdat_cpu_model_i.wr(C1, 8'h3f);
        rd_chk(ST, 8'h0f, 8'h0f);
        wdat_cpu_model_i.wr(C1, 8'h3e);
        wdat_cpu_model_i.wr(CM, 8'h4e);
        b0 = wn;
        b1 = oe_cyc;
        wait_chg(1, 40);
        chk_n(wn - b0, 1);
        wdat_cpu_model_i.wr(C1, 8'h3f);
        rd_chk(ST, 8'h02, 8'h00);
        wait_chg(1, 40);
        chk_n(wdat_cpu_model_i.depth, 2);
        hold <= 1'b1;
        b0 = wn;
        repeat (120) @(posedge clock);
        chk_n(wn - b0, 0);
        hold <= 1'b0;
        wait_chg(1, 40);
        chk_n(wn - b0, 1);
        chk_n(oe_cyc - b1, 0);
        // divided clock: one advance per fs_tick stretches the period fourfold
        div_sel <= 1'b1;
        wdat_cpu_model_i.wr(CM, 8'h4e);
        b0 = wn;
        repeat (88) @(posedge clock);
        chk_n(wn - b0, 0);
        wait_chg(1, 60);
        chk_n(wn - b0, 1);
        div_sel <= 1'b0;
        wdat_cpu_model_i.wr(CM, 8'h4e);
        wdat_cpu_model_i.wr(C1, 8'h06);
        wdat_cpu_model_i.wr(CM, 8'hb1);
        rd_chk(ST, 8'h0d, 8'h04);
        fetch_chk(16'h0100, 16'h0000, 1, 1);
        wdat_cpu_model_i.wr(CM, 8'hd2);
        rd_chk(ST, 8'h04, 8'h00);
        fetch_chk(16'h0100, 16'h0000, 1, 0);
        fetch_chk(16'h0010, 16'h0000, 1, 1);
        fetch_chk(16'h0000, 16'h003f, 2, 2);
        fetch_chk(16'h0040, 16'h0000, 1, 0);
        wdat_cpu_model_i.wr(C1, 8'h16);
        b1 = oe_cyc;
        fetch_chk(16'h0020, 16'h0000, 1, 0);
        repeat (40) @(posedge clock);
        chk_n(oe_cyc - b1, 24);
        low_speed <= 1'b1;
        osc_ready <= 1'b0;
        // let the low status pass the synchroniser before the trap
        repeat (6) @(posedge clock);
        fetch_chk(16'h0030, 16'h0000, 1, 0);
        repeat (20) @(posedge clock);
        chk({7'h00, osc_restart}, 8'h01);
        chk_n(oe_cyc - b1, 24);
        osc_ready <= 1'b1;
        repeat (40) @(posedge clock);
        chk_n(oe_cyc - b1, 48);
        summarize();
    end
endmodule
`default_nettype wire

// *** bench/wdat_cpu_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// cpu side: register accesses, fetches, nmi acceptance
module wdat_cpu_model (
    input wire logic clock,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr_stb,
    output logic rd_stb,
    input wire logic [7:0] rdata,
    output logic fetch_valid,
    output logic [15:0] fetch_addr,
    input wire logic overflow_nmi_request,
    input wire logic fetch_trap_nmi_request
);
    logic interrupt_master_flag = 1'b1;
    logic sp_ok = 1'b0;
    int depth = 0;
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        fetch_valid = 1'b0;
        fetch_addr = 16'h0000;
    end
    task automatic master_off();
        interrupt_master_flag = 1'b0;
    endtask
    // idle bus shows inverted data so stale values never match by luck
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a == wdat_pkg::CTRL_ONE_ADDR && d[wdat_pkg::BIT_OUT] == 1'b0) sp_ok = 1'b1;
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        addr <= ~a;
        @(posedge clock);
        d = rdata;
    endtask
    task automatic fetch(input logic [15:0] a, input logic [15:0] b, input int n);
        @(posedge clock);
        fetch_valid <= 1'b1;
        fetch_addr <= a;
        if (n == 2) begin
            @(posedge clock);
            fetch_addr <= b;
        end
        @(posedge clock);
        fetch_valid <= 1'b0;
        fetch_addr <= ~fetch_addr;
    endtask
    // taken whatever imf holds, nesting deeper
    always @(posedge clock) begin
        if (sp_ok && (overflow_nmi_request === 1'b1 || fetch_trap_nmi_request === 1'b1)) begin
            depth <= depth + 1;
        end
    end
endmodule
`default_nettype wire

// *** hw/wdat_divider.sv ***
`timescale 1ns/10ps
`default_nettype none
// free-running prescaler; tick marks the end of each 2^(tap+1) advance period
module wdat_divider (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic hold,
    input wire logic use_fs,
    input wire logic fs_tick,
    input wire logic [4:0] tap,
    output logic tick
);
    logic [wdat_pkg::DIV_W-1:0] cnt_q;
    logic [wdat_pkg::DIV_W-1:0] mask;
    logic adv;
    logic tick_q;
    assign adv = !hold && (!use_fs || fs_tick);
    assign mask = wdat_pkg::DIV_W'((25'h1 << ({20'h0, tap} + 25'h1)) - 25'h1);
    assign tick = tick_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= adv ? cnt_q + 1'b1 : cnt_q;
            tick_q <= adv && ((cnt_q & mask) == mask);
        end
    end
endmodule
`default_nettype wire

// *** hw/wdat_pkg.sv ***
// Function
// - enable bit resets to one; writing one to it enables counting.
// - disable code works only while the enable bit already holds zero.
// - while disabled the binary counter is held cleared.
// - clear code clears the binary counter only; the divider keeps running.
// - action select zero: overflow raises the overflow interrupt request.
// - overflow interrupt is non-maskable, independent of the master flag.
// - a new overflow interrupt is issued even while another is serviced.
// - once action select is zero, writes of one are ignored until reset.
// - action select one: overflow drives the reset pin low, resets hardware.
// - a watchdog or trap reset lasts at most 24 fast clock periods.
// - counting pauses during stop, warm-up, idle and sleep, then resumes.
// - new ram trap select takes effect only after command D2 is written.
// - a fetch from the register area always traps.
// - trap action zero: trapped fetch raises the trap interrupt request.
// - trap interrupt is non-maskable and issued even during other servicing.
// - trap action one: trapped fetch drives a system reset.
// - trap reset in low-speed mode restarts fast oscillator, timed from it.
`default_nettype none
package wdat_pkg;
    localparam logic [7:0] CTRL_ONE_ADDR = 8'h34;
    localparam logic [7:0] CMD_ADDR = 8'h35;
    localparam logic [7:0] STATUS_ADDR = 8'h36;
    localparam int BIT_OUT = 0;
    localparam int BIT_TT = 1;
    localparam int BIT_EN = 3;
    localparam int BIT_TRAP_ACTION_SELECT = 4;
    localparam int BIT_RAM_TRAP_SELECT = 5;
    localparam logic OUT_RST = 1'b1;
    localparam logic [1:0] TT_RST = 2'h0;
    localparam logic EN_RST = 1'b1;
    localparam logic TRAP_ACTION_SELECT_RST = 1'b1;
    localparam logic RAM_TRAP_SELECT_RST = 1'b1;
    localparam logic [7:0] CLEAR_CODE = 8'h4e;
    localparam logic [7:0] DISABLE_CODE = 8'hb1;
    localparam logic [7:0] TRAP_APPLY_CODE = 8'hd2;
    localparam logic [1:0] BIN_LAST = 2'h3;
    localparam int DIV_W = 24;
    localparam int FC_TAP_BASE = 22;
    localparam int FS_TAP_BASE = 14;
    localparam int RST_FC_PERIODS = 24;
    localparam int FC_PERIOD_PS = 4000;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int RST_CYCLES = (RST_FC_PERIODS * FC_PERIOD_PS) / CLK_PERIOD_PS;
    localparam logic [4:0] RST_CNT_LAST = 5'(RST_CYCLES - 1);
    localparam logic [15:0] SFR_LO = 16'h0000;
    localparam logic [15:0] SFR_HI = 16'h003f;
    localparam logic [15:0] RAM_LO = 16'h0040;
    localparam logic [15:0] RAM_HI = 16'h023f;
    typedef enum logic [1:0] {RS_IDLE, RS_WAIT_OSC, RS_DRIVE} wdat_rst_e;
endpackage
`default_nettype wire

// *** hw/wdat_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module wdat_top #(
    parameter int FC_TAP_BASE = wdat_pkg::FC_TAP_BASE,
    parameter int FS_TAP_BASE = wdat_pkg::FS_TAP_BASE
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic fetch_valid,
    input wire logic [15:0] fetch_addr,
    input wire logic low_speed_clock_mode,
    input wire logic divider_stage_clock_select,
    input wire logic fs_tick,
    input wire logic clock_hold,
    input wire logic hf_osc_ready,
    output logic overflow_nmi_request,
    output logic fetch_trap_nmi_request,
    output logic reset_pin_o,
    output logic reset_pin_oe,
    output logic internal_reset,
    output logic hf_osc_restart
);
    logic rst_meta_q;
    logic rst_n_q;
    logic en_bit_q;
    logic out_sel_q;
    logic [1:0] tt_q;
    logic trap_action_select_q;
    logic ram_trap_select_q;
    logic active_q;
    logic ram_trap_q;
    logic [1:0] bin_q;
    logic [1:0] bin_d;
    logic ovf_nmi_q;
    logic trap_nmi_q;
    logic pin_oe_q;
    logic osc_q;
    logic [7:0] rdata_q;
    logic [4:0] rst_cnt_q;
    logic [4:0] rst_cnt_d;
    logic osc_s1_q;
    logic osc_s2_q;
    logic osc_s3_q;
    logic osc_ready_q;
    wdat_pkg::wdat_rst_e rs_q;
    wdat_pkg::wdat_rst_e rs_d;

    wire wr_ctrl = wr_stb && (addr == wdat_pkg::CTRL_ONE_ADDR);
    wire wr_cmd = wr_stb && (addr == wdat_pkg::CMD_ADDR);
    wire rd_status = rd_stb && (addr == wdat_pkg::STATUS_ADDR);
    wire clr_cmd = wr_cmd && (wdata == wdat_pkg::CLEAR_CODE);
    wire dis_cmd = wr_cmd && (wdata == wdat_pkg::DISABLE_CODE);
    wire apply_cmd = wr_cmd && (wdata == wdat_pkg::TRAP_APPLY_CODE);
    wire use_fs = divider_stage_clock_select || low_speed_clock_mode;
    wire [4:0] fc_tap = 5'(FC_TAP_BASE) - {2'h0, tt_q, 1'b0};
    wire [4:0] fs_tap = 5'(FS_TAP_BASE) - {2'h0, tt_q, 1'b0};
    wire [4:0] tap = use_fs ? fs_tap : fc_tap;
    wire div_tick;
    wire tick = div_tick && !clock_hold;
    // overflow after the fourth divided tick
    wire overflow = active_q && tick && !clr_cmd && (bin_q == wdat_pkg::BIN_LAST);
    wire sfr_hit = (fetch_addr >= wdat_pkg::SFR_LO) && (fetch_addr <= wdat_pkg::SFR_HI);
    wire ram_hit = (fetch_addr >= wdat_pkg::RAM_LO) && (fetch_addr <= wdat_pkg::RAM_HI);
    // register area traps regardless of ram select
    wire trap = fetch_valid && (sfr_hit || (ram_hit && ram_trap_q));
    wire rst_evt = (overflow && out_sel_q) || (trap && trap_action_select_q);
    wire [7:0] status = {2'h0, bin_q, trap_action_select_q, ram_trap_q, out_sel_q, active_q};

    // reset released through two flops
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // oscillator status is asynchronous; a level counts once two stages agree
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
            osc_ready_q <= 1'b0;
        end else begin
            osc_s1_q <= hf_osc_ready;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
            osc_ready_q <= (osc_s2_q == osc_s3_q) ? osc_s3_q : osc_ready_q;
        end
    end

    wdat_divider u_div (
        .clock(clock),
        .rst_n(rst_n_q),
        .hold(clock_hold),
        .use_fs(use_fs),
        .fs_tick(fs_tick),
        .tap(tap),
        .tick(div_tick)
    );

    // control one is write-only; fields kept as written
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            en_bit_q <= wdat_pkg::EN_RST;
            tt_q <= wdat_pkg::TT_RST;
            trap_action_select_q <= wdat_pkg::TRAP_ACTION_SELECT_RST;
            ram_trap_select_q <= wdat_pkg::RAM_TRAP_SELECT_RST;
        end else if (wr_ctrl) begin
            en_bit_q <= wdata[wdat_pkg::BIT_EN];
            tt_q <= wdata[wdat_pkg::BIT_TT +: 2];
            trap_action_select_q <= wdata[wdat_pkg::BIT_TRAP_ACTION_SELECT];
            ram_trap_select_q <= wdata[wdat_pkg::BIT_RAM_TRAP_SELECT];
        end
    end

    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            out_sel_q <= wdat_pkg::OUT_RST;
        end else if (wr_ctrl) begin
            out_sel_q <= out_sel_q && wdata[wdat_pkg::BIT_OUT];
        end
    end

    // enable by bit, disable by code
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            active_q <= wdat_pkg::EN_RST;
        end else if (wr_ctrl && wdata[wdat_pkg::BIT_EN]) begin
            active_q <= 1'b1;
        end else if (dis_cmd && !en_bit_q) begin
            active_q <= 1'b0;
        end
    end

    // ram select copied only on apply code
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ram_trap_q <= wdat_pkg::RAM_TRAP_SELECT_RST;
        end else if (apply_cmd) begin
            ram_trap_q <= ram_trap_select_q;
        end
    end

    // clear on disable or clear code
    always_comb begin
        bin_d = bin_q;
        if (!active_q || clr_cmd) begin
            bin_d = 2'h0;
        end else if (tick) begin
            bin_d = bin_q + 2'h1;
        end
    end

    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            bin_q <= 2'h0;
        end else begin
            bin_q <= bin_d;
        end
    end

    // pulses ignore master flag and nesting
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ovf_nmi_q <= 1'b0;
            trap_nmi_q <= 1'b0;
        end else begin
            ovf_nmi_q <= overflow && !out_sel_q;
            trap_nmi_q <= trap && !trap_action_select_q;
        end
    end

    // reset sequencer; slow mode waits for fast oscillator first
    always_comb begin
        rs_d = rs_q;
        rst_cnt_d = rst_cnt_q;
        case (rs_q)
            wdat_pkg::RS_IDLE: begin
                if (rst_evt && low_speed_clock_mode) begin
                    rs_d = wdat_pkg::RS_WAIT_OSC;
                end else if (rst_evt) begin
                    rs_d = wdat_pkg::RS_DRIVE;
                    rst_cnt_d = wdat_pkg::RST_CNT_LAST;
                end
            end
            wdat_pkg::RS_WAIT_OSC: begin
                if (osc_ready_q) begin
                    rs_d = wdat_pkg::RS_DRIVE;
                    rst_cnt_d = wdat_pkg::RST_CNT_LAST;
                end
            end
            wdat_pkg::RS_DRIVE: begin
                if (rst_cnt_q == 5'h0) begin
                    rs_d = wdat_pkg::RS_IDLE;
                end else begin
                    rst_cnt_d = rst_cnt_q - 5'h1;
                end
            end
            default: begin
                rs_d = wdat_pkg::RS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rs_q <= wdat_pkg::RS_IDLE;
            rst_cnt_q <= 5'h0;
            pin_oe_q <= 1'b0;
            osc_q <= 1'b0;
        end else begin
            rs_q <= rs_d;
            rst_cnt_q <= rst_cnt_d;
            pin_oe_q <= (rs_d == wdat_pkg::RS_DRIVE);
            osc_q <= (rs_d == wdat_pkg::RS_WAIT_OSC);
        end
    end

    // read data only in the cycle after the strobe
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rd_status ? status : 8'h00;
        end
    end

    // open-drain pin: value always low, enable decides
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reset_pin_o <= 1'b0;
        end else begin
            reset_pin_o <= 1'b0;
        end
    end

    assign rdata = rdata_q;
    assign overflow_nmi_request = ovf_nmi_q;
    assign fetch_trap_nmi_request = trap_nmi_q;
    assign reset_pin_oe = pin_oe_q;
    assign internal_reset = pin_oe_q;
    assign hf_osc_restart = osc_q;

    logic [5:0] drive_len_q;
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            drive_len_q <= 6'h0;
        end else begin
            drive_len_q <= pin_oe_q ? drive_len_q + 6'h1 : 6'h0;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n_q);

    enable_write_a: assert property (wr_ctrl && wdata[wdat_pkg::BIT_EN] |=> active_q)
        else $error("enable write did not start the watchdog");
    disable_guard_a: assert property (dis_cmd && en_bit_q |=> active_q == $past(active_q))
        else $error("disable code honoured while enable bit set");
    idle_clear_a: assert property (!active_q [*2] |-> bin_q == 2'h0)
        else $error("binary counter not cleared while disabled");
    clear_code_a: assert property (clr_cmd |=> bin_q == 2'h0)
        else $error("clear code did not clear binary counter");
    ovf_nmi_a: assert property (overflow && !out_sel_q |=> overflow_nmi_request && !reset_pin_oe)
        else $error("overflow in interrupt mode gave no request");
    ovf_reset_a: assert property (overflow && out_sel_q && rs_q == wdat_pkg::RS_IDLE
        && !low_speed_clock_mode |=> reset_pin_oe && internal_reset)
        else $error("overflow in reset mode gave no reset");
    sel_sticky_a: assert property (!out_sel_q |=> !out_sel_q)
        else $error("action select returned to one");
    reset_len_a: assert property (drive_len_q <= 6'(wdat_pkg::RST_CYCLES))
        else $error("reset pin held low too long");
    hold_stall_a: assert property (clock_hold && active_q && !wr_cmd |=> $stable(bin_q))
        else $error("counter moved while held");
    ram_apply_a: assert property (apply_cmd |=> ram_trap_q == $past(ram_trap_select_q))
        else $error("ram select not applied by command");
    ram_hold_a: assert property (!apply_cmd |=> $stable(ram_trap_q))
        else $error("ram select changed without command");
    sfr_trap_a: assert property (fetch_valid && sfr_hit && !trap_action_select_q |=> fetch_trap_nmi_request)
        else $error("register area fetch not trapped");
    ram_trap_a: assert property (fetch_valid && ram_hit && ram_trap_q && !trap_action_select_q |=> fetch_trap_nmi_request)
        else $error("ram fetch not trapped");
    osc_wait_a: assert property (rs_q == wdat_pkg::RS_WAIT_OSC && !osc_ready_q |=> hf_osc_restart && !reset_pin_oe)
        else $error("reset driven before fast oscillator ready");
    trap_reset_a: assert property (trap && trap_action_select_q && rs_q == wdat_pkg::RS_IDLE
        && !low_speed_clock_mode |=> reset_pin_oe)
        else $error("trap in reset mode gave no reset");
    slow_osc_a: assert property (trap && trap_action_select_q && rs_q == wdat_pkg::RS_IDLE
        && low_speed_clock_mode |=> hf_osc_restart && !reset_pin_oe)
        else $error("slow trap reset skipped oscillator restart");
    wrap_count_a: assert property (active_q && tick && !clr_cmd && bin_q == 2'h3
        |=> bin_q == 2'h0)
        else $error("binary counter did not wrap on overflow");

    ovf_nmi_c: cover property (overflow_nmi_request);
    trap_nmi_c: cover property (fetch_trap_nmi_request);
    reset_drive_c: cover property (reset_pin_oe ##1 !reset_pin_oe);
    disable_c: cover property (dis_cmd && !en_bit_q ##1 !active_q);
endmodule
`default_nettype wire
